// ===== tesc_term.sv
// Terminal-side codec: buffers and parses analyzer output, sends cursor keys back.
// Assumes byte streams from a serial receiver/transmitter on core_clk.
module tesc_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] DEPTH = (AW+1)'(D);

	logic [W-1:0]  mem_reg [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	logic [AW:0]   cnt_next;
	logic          push;
	logic          pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_reg];

	always_comb begin
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = cnt_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_next = cnt_reg - (AW+1)'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	// Flags registered so the top-level ready comes straight from a flop
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			cnt_reg   <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + AW'(1);
			end
			if (pop) begin
				rd_reg <= rd_reg + AW'(1);
			end
			cnt_reg   <= cnt_next;
			in_ready  <= (cnt_next != DEPTH);
			out_valid <= (cnt_next != '0);
		end
	end
endmodule : tesc_fifo

module tesc_term (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic [7:0]   rx_byte,
	input  wire logic         rx_valid,
	output logic              rx_ready,
	input  wire logic         disp_busy,
	output logic [7:0]        char_byte,
	output logic              char_valid,
	output logic              attr_inverse,
	output logic              clr_to_eos,
	output logic              clr_screen,
	output logic              clr_to_eol,
	output logic              clr_line,
	output logic [7:0]        cur_row,
	output logic [7:0]        cur_col,
	output logic              cur_set,
	input  wire logic         key_up,
	input  wire logic         key_down,
	input  wire logic         key_right,
	input  wire logic         key_left,
	output logic              key_ready,
	output logic [7:0]        tx_byte,
	output logic              tx_valid,
	input  wire logic         tx_ready
);
	import tesc_pkg::*;

	// ==========================================================
	// Input buffer
	logic [7:0]   fb;
	logic         f_valid;
	logic         pop;

	// Display backpressure stalls the parser, so the buffer really fills
	assign pop = f_valid && !disp_busy;

	tesc_fifo #(.W(TESC_FIFO_W), .D(TESC_FIFO_D)) u_fifo (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.in_data   (rx_byte),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.out_data  (fb),
		.out_valid (f_valid),
		.out_ready (!disp_busy)
	);

	// ==========================================================
	// Byte classes
	logic is_esc;
	logic is_digit;
	logic is_sep;
	logic is_term;
	logic is_print;

	assign is_esc   = (fb == TESC_CH_ESC);
	assign is_digit = (fb >= TESC_CH_DIG0) && (fb <= TESC_CH_DIG9);
	assign is_sep   = (fb == TESC_CH_SEMI) || (fb == TESC_CH_COLON);
	assign is_term  = (fb >= TESC_TERM_LO) && (fb <= TESC_PRINT_HI);
	assign is_print = (fb >= TESC_PRINT_LO) && (fb <= TESC_PRINT_HI);

	// ==========================================================
	// Parser state
	tesc_pstate_t pst_reg;
	logic         in_seq;
	logic         dispatch;

	assign in_seq = (pst_reg == P_ESC) || (pst_reg == P_PARAM);
	assign dispatch = pop && in_seq && is_term && !(pst_reg == P_ESC && fb == TESC_CH_LBRK);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pst_reg <= P_IDLE;
		end else if (pop) begin
			case (pst_reg)
				P_IDLE: begin
					if (is_esc) begin
						pst_reg <= P_ESC;
					end
				end
				P_ESC, P_PARAM: begin
					if (is_esc) begin
						pst_reg <= P_ESC;
					end else if (pst_reg == P_ESC && fb == TESC_CH_LBRK) begin
						pst_reg <= P_PARAM;
					end else if (is_digit || is_sep) begin
						pst_reg <= P_PARAM;
					end else begin
						// Terminator or any other non-parameter byte, printable or not, ends the sequence
						pst_reg <= P_IDLE;
					end
				end
				default: pst_reg <= P_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Parameter collection; only the first two are kept
	logic [7:0]  p0_reg;
	logic [7:0]  p1_reg;
	logic        idx_reg;
	logic        pres0_reg;
	logic        pres1_reg;
	logic        neg1_reg;
	logic        over_reg;
	logic [11:0] acc;
	logic [7:0]  acc_sat;

	assign acc = ((idx_reg ? {4'h0, p1_reg} : {4'h0, p0_reg}) * 12'h00A)
		+ {8'h00, fb[3:0]};
	assign acc_sat = (acc > {4'h0, TESC_PV_MAX}) ? TESC_PV_MAX : acc[7:0];

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			p0_reg    <= '0;
			p1_reg    <= '0;
			idx_reg   <= 1'b0;
			pres0_reg <= 1'b0;
			pres1_reg <= 1'b0;
			neg1_reg  <= 1'b0;
			over_reg  <= 1'b0;
		end else if (pop) begin
			if (is_esc || !in_seq) begin
				p0_reg    <= '0;
				p1_reg    <= '0;
				idx_reg   <= 1'b0;
				pres0_reg <= 1'b0;
				pres1_reg <= 1'b0;
				neg1_reg  <= 1'b0;
				over_reg  <= 1'b0;
			end else if (is_digit && !over_reg) begin
				if (idx_reg) begin
					p1_reg    <= acc_sat;
					pres1_reg <= 1'b1;
				end else begin
					p0_reg    <= acc_sat;
					pres0_reg <= 1'b1;
				end
			end else if (is_sep) begin
				if (idx_reg) begin
					over_reg <= 1'b1;
				end else begin
					idx_reg  <= 1'b1;
					neg1_reg <= (fb == TESC_CH_COLON);
				end
			end
		end
	end

	// ==========================================================
	// Effective values for the terminating byte
	logic       v0_ok;
	logic [7:0] v0;
	logic       row_ok;
	logic       col_ok;

	// Only the second field can follow a colon; negative counts as missing
	assign v0_ok = pres0_reg;
	assign v0 = v0_ok ? p0_reg : TESC_PV_TO_END;
	assign row_ok = v0_ok && (p0_reg >= TESC_COORD_MIN) && (p0_reg <= TESC_ROWS);
	assign col_ok = pres1_reg && !neg1_reg
		&& (p1_reg >= TESC_COORD_MIN) && (p1_reg <= TESC_COLS);

	// ==========================================================
	// Display actions
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			char_byte    <= '0;
			char_valid   <= 1'b0;
			attr_inverse <= 1'b0;
			clr_to_eos   <= 1'b0;
			clr_screen   <= 1'b0;
			clr_to_eol   <= 1'b0;
			clr_line     <= 1'b0;
			cur_row      <= TESC_COORD_MIN;
			cur_col      <= TESC_COORD_MIN;
			cur_set      <= 1'b0;
		end else begin
			char_valid <= 1'b0;
			clr_to_eos <= 1'b0;
			clr_screen <= 1'b0;
			clr_to_eol <= 1'b0;
			clr_line   <= 1'b0;
			cur_set    <= 1'b0;
			if (pop && pst_reg == P_IDLE && is_print) begin
				char_byte  <= fb;
				char_valid <= 1'b1;
			end
			if (dispatch) begin
				case (fb)
					TESC_CH_ATTR: begin
						if (v0 == TESC_PV_NORMAL) begin
							attr_inverse <= 1'b0;
						end else if (v0 == TESC_PV_INVERSE) begin
							attr_inverse <= 1'b1;
						end
					end
					TESC_CH_CLRS: begin
						clr_to_eos <= (v0 == TESC_PV_TO_END);
						clr_screen <= (v0 == TESC_PV_ALL);
					end
					TESC_CH_CLRL: begin
						clr_to_eol <= (v0 == TESC_PV_TO_END);
						clr_line   <= (v0 == TESC_PV_ALL);
					end
					TESC_CH_POS: begin
						cur_row <= row_ok ? p0_reg : TESC_COORD_MIN;
						cur_col <= col_ok ? p1_reg : TESC_COORD_MIN;
						cur_set <= 1'b1;
					end
					default: char_valid <= 1'b0;
				endcase
			end
		end
	end

	// ==========================================================
	// Cursor key sender: escape then direction letter
	tesc_gstate_t gst_reg;
	logic [7:0]   key_reg;
	logic [7:0]   key_next;
	logic         key_any;
	assign key_any = key_up || key_down || key_right || key_left;
	// Fixed priority when several keys pulse together
	always_comb begin
		key_next = TESC_CH_LEFT;
		if (key_up) begin
			key_next = TESC_CH_UP;
		end else if (key_down) begin
			key_next = TESC_CH_DOWN;
		end else if (key_right) begin
			key_next = TESC_CH_RIGHT;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gst_reg   <= G_IDLE;
			key_reg   <= '0;
			key_ready <= 1'b1;
			tx_byte   <= '0;
			tx_valid  <= 1'b0;
		end else begin
			case (gst_reg)
				G_IDLE: begin
					if (key_any) begin
						key_reg   <= key_next;
						tx_byte   <= TESC_CH_ESC;
						tx_valid  <= 1'b1;
						key_ready <= 1'b0;
						gst_reg   <= G_ESC;
					end
				end
				G_ESC: begin
					if (tx_ready) begin
						tx_byte <= key_reg;
						gst_reg <= G_KEY;
					end
				end
				G_KEY: begin
					if (tx_ready) begin
						tx_valid  <= 1'b0;
						key_ready <= 1'b1;
						gst_reg   <= G_IDLE;
					end
				end
				default: gst_reg <= G_IDLE;
			endcase
		end
	end
endmodule : tesc_term

// ===== tesc_pkg.sv
// Constants for the terminal-side escape sequence codec.
// Assumes byte-wide character streams on the core_clk domain.
// Function
// - Sequences open with escape 0x1B alone, or escape then bracket 0x5B.
// - Numeric parameters are decimal, one ASCII digit 0x30..0x39 per digit.
// - Consecutive parameters are separated by semicolon 0x3B.
// - A negative parameter is preceded by colon 0x3A instead of semicolon.
// - One printable terminator byte ends a sequence and selects its action.
// - Terminator m: parameter 0 selects normal video, 7 inverse video.
// - Terminator J: 0 clears cursor to end of screen, 2 whole screen.
// - Terminator K: 0 clears cursor to end of line, 2 whole line.
// - Cursor position is bracket intro, row, semicolon, column, then H.
// - Display is 25 rows by 80 columns, both counted from 1.
// - Missing or out-of-range movement parameters are replaced by 1.
// - Escape followed by A, B, C or D moves cursor up, down, right, left.
package tesc_pkg;

	// ==========================================================
	// Character codes
	localparam logic [7:0] TESC_CH_ESC   = 8'h1B;
	localparam logic [7:0] TESC_CH_LBRK  = 8'h5B;
	localparam logic [7:0] TESC_CH_DIG0  = 8'h30;
	localparam logic [7:0] TESC_CH_DIG9  = 8'h39;
	localparam logic [7:0] TESC_CH_SEMI  = 8'h3B;
	localparam logic [7:0] TESC_CH_COLON = 8'h3A;
	localparam logic [7:0] TESC_CH_ATTR  = 8'h6D;
	localparam logic [7:0] TESC_CH_CLRS  = 8'h4A;
	localparam logic [7:0] TESC_CH_CLRL  = 8'h4B;
	localparam logic [7:0] TESC_CH_POS   = 8'h48;
	localparam logic [7:0] TESC_CH_UP    = 8'h41;
	localparam logic [7:0] TESC_CH_DOWN  = 8'h42;
	localparam logic [7:0] TESC_CH_RIGHT = 8'h43;
	localparam logic [7:0] TESC_CH_LEFT  = 8'h44;
	localparam logic [7:0] TESC_PRINT_LO = 8'h20;
	localparam logic [7:0] TESC_PRINT_HI = 8'h7E;
	localparam logic [7:0] TESC_TERM_LO  = 8'h40;

	// ==========================================================
	// Parameter values and display geometry
	localparam logic [7:0] TESC_PV_NORMAL  = 8'h00;
	localparam logic [7:0] TESC_PV_INVERSE = 8'h07;
	localparam logic [7:0] TESC_PV_TO_END  = 8'h00;
	localparam logic [7:0] TESC_PV_ALL     = 8'h02;
	localparam logic [7:0] TESC_PV_MAX     = 8'hFF;
	localparam logic [7:0] TESC_ROWS       = 8'h19;
	localparam logic [7:0] TESC_COLS       = 8'h50;
	localparam logic [7:0] TESC_COORD_MIN  = 8'h01;

	// ==========================================================
	// Buffering
	localparam int TESC_FIFO_W = 8;
	localparam int TESC_FIFO_D = 32;

	typedef enum logic [1:0] {P_IDLE, P_ESC, P_PARAM} tesc_pstate_t;
	typedef enum logic [1:0] {G_IDLE, G_ESC, G_KEY} tesc_gstate_t;

endpackage : tesc_pkg

// ===== tesc_term_monitor.sv
// Checker for tesc_term, bound to its top ports.
// Assumes one core_clk domain and nrst asynchronous, active low.
module tesc_term_monitor
	import tesc_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic       key_up,
	input wire logic       key_left,
	input wire logic       key_ready,
	input wire logic [7:0] tx_byte,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       clr_to_eos,
	input wire logic       clr_screen,
	input wire logic       clr_to_eol,
	input wire logic       clr_line,
	input wire logic [7:0] cur_row,
	input wire logic [7:0] cur_col,
	input wire logic       cur_set
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Key reply sequences
	sequence s_esc_up;
		key_ready && key_up ##1 tx_valid && tx_ready;
	endsequence
	a_key_esc_first: assert property (
		key_ready && (key_up || key_left) |=> tx_valid && tx_byte == TESC_CH_ESC && !key_ready)
		else $error("key not answered by escape");
	a_key_up_letter: assert property (s_esc_up |=> tx_valid && tx_byte == TESC_CH_UP)
		else $error("up key letter wrong");
	a_key_pair_done: assert property (
		tx_valid && tx_ready && tx_byte != TESC_CH_ESC |=> !tx_valid && key_ready)
		else $error("key reply longer than two bytes");
	a_tx_byte_held: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("tx byte dropped while stalled");
	// ==========================================================
	// Display actions
	a_clear_one_cycle: assert property (
		clr_screen || clr_line |=> !clr_screen && !clr_line)
		else $error("clear pulse too long");
	a_clear_exclusive: assert property (
		!(clr_to_eos && clr_screen) && !(clr_to_eol && clr_line))
		else $error("two clear kinds at once");
	a_cursor_in_range: assert property (
		cur_row inside {[8'h01:8'h19]} && cur_col inside {[8'h01:8'h50]})
		else $error("cursor outside display");
	a_cursor_moves_set: assert property (
		$changed(cur_row) || $changed(cur_col) |-> cur_set)
		else $error("cursor moved without set pulse");
endmodule : tesc_term_monitor

bind tesc_term tesc_term_monitor i_tesc_term_monitor (.core_clk(core_clk), .nrst(nrst),
	.key_up(key_up), .key_left(key_left), .key_ready(key_ready), .tx_byte(tx_byte),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .clr_to_eos(clr_to_eos),
	.clr_screen(clr_screen), .clr_to_eol(clr_to_eol), .clr_line(clr_line),
	.cur_row(cur_row), .cur_col(cur_col), .cur_set(cur_set));

// ===== tesc_host_model.sv
// Analyzer-side model: sends escape text, decodes cursor keys sent back.
// Assumes tesc_term valid/ready byte handshakes on core_clk.
module tesc_host_model
	import tesc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rx_ready,
	input  wire logic       slow,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_valid,
	output logic            tx_ready,
	output logic [7:0]      key_got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic esc_seen;
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
		key_got = 8'h00;
		esc_seen = 1'b0;
	end
	// Called at a rising edge; holds each byte until rx_ready is seen
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			rx_byte <= s[i];
			rx_valid <= 1'b1;
			@(negedge core_clk);
			while (!rx_ready) @(negedge core_clk);
			@(posedge core_clk);
		end
		rx_valid <= 1'b0;
		// Released line shows garbage, not the last byte
		rx_byte <= ~rx_byte;
	endtask : send
	always @(posedge core_clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			esc_seen <= (tx_byte == TESC_CH_ESC);
			if (esc_seen && tx_byte inside {[TESC_CH_UP:TESC_CH_LEFT]}) begin
				key_got <= tx_byte;
			end
		end
	end
endmodule : tesc_host_model

// ===== terminal_escape_codec_tb.sv
// Testbench for tesc_term with the analyzer model on its far side.
// Assumes tesc_pkg, tesc_term and tesc_host_model are compiled first.
module terminal_escape_codec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, nrst, disp_busy, slow;
	logic [3:0] keys;
	logic [7:0] rx_byte, char_byte, cur_row, cur_col, tx_byte, key_got;
	logic rx_valid, rx_ready, char_valid, attr_inverse, clr_to_eos, clr_screen, clr_to_eol;
	logic clr_line, cur_set, key_ready, tx_valid, tx_ready;
	int fail_count = 0;
	int comparisons = 0;
	int cnt [5] = '{default: 0};
	tesc_term i_tesc_term (.core_clk(core_clk), .nrst(nrst), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .disp_busy(disp_busy), .char_byte(char_byte),
		.char_valid(char_valid), .attr_inverse(attr_inverse), .clr_to_eos(clr_to_eos),
		.clr_screen(clr_screen), .clr_to_eol(clr_to_eol), .clr_line(clr_line),
		.cur_row(cur_row), .cur_col(cur_col), .cur_set(cur_set), .key_up(keys[0]),
		.key_down(keys[1]), .key_right(keys[2]), .key_left(keys[3]), .key_ready(key_ready),
		.tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
	tesc_host_model i_tesc_host_model (.core_clk(core_clk), .rx_ready(rx_ready), .slow(slow),
		.tx_byte(tx_byte), .tx_valid(tx_valid), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.tx_ready(tx_ready), .key_got(key_got));
	// ==========================================================
	// Pulse counting and helpers
	always @(posedge core_clk) if (nrst) begin
		cnt[0] += clr_to_eos;
		cnt[1] += clr_screen;
		cnt[2] += clr_to_eol;
		cnt[3] += clr_line;
		cnt[4] += char_valid;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic run(input string s);
		@(posedge core_clk);
		i_tesc_host_model.send(s);
		repeat (6) @(negedge core_clk);
	endtask : run
	// ==========================================================
	// Scenarios
	task automatic t_attr;
		run("\033[7m");
		chk("inverse", 8'h01, {7'h00, attr_inverse});
		run("\0330m");
		chk("normal", 8'h00, {7'h00, attr_inverse});
	endtask : t_attr
	task automatic t_clear;
		string s [4] = '{"\033[0J", "\033[2J", "\033[0K", "\033[2K"};
		int b [5];
		for (int i = 0; i < 4; i++) begin
			b = cnt;
			run(s[i]);
			for (int k = 0; k < 4; k++) chk("clear", 8'(k == i), 8'(cnt[k] - b[k]));
		end
	endtask : t_clear
	task automatic t_pos;
		string s [6] = '{"\033[12;34H", "\033[25;80H", "\033[26;81H", "\033[;7H", "\033[3:4H",
			"\033[1;2;3H"};
		logic [7:0] r [6] = '{8'h0C, 8'h19, 8'h01, 8'h01, 8'h03, 8'h01};
		logic [7:0] c [6] = '{8'h22, 8'h50, 8'h01, 8'h07, 8'h01, 8'h02};
		for (int i = 0; i < 6; i++) begin
			run(s[i]);
			chk("row", r[i], cur_row);
			chk("column", c[i], cur_col);
		end
	endtask : t_pos
	task automatic t_unknown;
		int b [5];
		int d;
		b = cnt;
		run("\033[5Zx");
		chk("chars", 8'h01, 8'(cnt[4] - b[4]));
		chk("char", 8'h78, char_byte);
		d = cnt[0] + cnt[1] + cnt[2] + cnt[3] - b[0] - b[1] - b[2] - b[3];
		chk("clears", 8'h00, 8'(d));
	endtask : t_unknown
	task automatic t_keys;
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			slow <= (i == 4);
			keys <= (i == 4) ? 4'h9 : 4'h1 << i;
			@(posedge core_clk);
			keys <= 4'h0;
			for (int n = 0; n < 20; n++) begin
				@(negedge core_clk);
				if (key_ready) break;
			end
			chk("key", (i == 4) ? 8'h41 : 8'(8'h41 + i), key_got);
		end
		slow <= 1'b0;
	endtask : t_keys
	task automatic t_fifo;
		int b [5];
		b = cnt;
		@(posedge core_clk);
		disp_busy <= 1'b1;
		run("ABCDEFGHIJKLMNOPQRSTUVWXYZabcdef");
		chk("full", 8'h00, {7'h00, rx_ready});
		@(posedge core_clk);
		disp_busy <= 1'b0;
		repeat (40) @(negedge core_clk);
		chk("drained", 8'h20, 8'(cnt[4] - b[4]));
	endtask : t_fifo
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// ==========================================================
	// Clock, sequence and watchdog
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		nrst = 1'b0;
		disp_busy = 1'b0;
		slow = 1'b0;
		keys = 4'h0;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		@(negedge core_clk);
		chk("row reset", 8'h01, cur_row);
		chk("column reset", 8'h01, cur_col);
		t_attr;
		t_clear;
		t_pos;
		t_unknown;
		t_keys;
		t_fifo;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		stop_test;
	end
endmodule : terminal_escape_codec_tb
